// ==== core/sfcfg_pkg.sv ====
// constants, field layouts and types for the synth config word decoder
// assumes a 24-bit serial word with its select nibble in the low 4 bits
`default_nettype none

package sfcfg_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 4;
  localparam int BASE_W = 12;
  localparam int EXT_W = 10;
  localparam int FRAC_W = 22;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h18;

  // word select nibbles
  localparam logic [SEL_W-1:0] SEL_CFG4 = 4'h9;
  localparam logic [SEL_W-1:0] SEL_FRAC_EXT = 4'hB;
  localparam logic [SEL_W-1:0] SEL_ACCESS = 4'h3;
  localparam logic [SEL_W-1:0] SEL_FREQ_MASK = 4'h1;
  localparam logic [SEL_W-1:0] SEL_FREQ_VAL = 4'h0;

  // config_word_four fields
  localparam int CFG4_AUTO_WAKE = 23;
  localparam int CFG4_DITHER_SELECT_LSB = 16;
  localparam int CFG4_ORDER_LSB = 14;
  localparam int CFG4_DOUBLER = 12;
  localparam int CFG4_REF_OUT = 11;
  localparam int CFG4_AUX_CPP = 10;
  localparam int CFG4_MAIN_CPP = 9;
  localparam int CFG4_AUX_PRESC = 8;

  // frac_extension_word fields
  localparam int EXT_DEN_LSB = 14;
  localparam int EXT_NUM_LSB = 4;

  // access_control_word fields
  localparam int ACC_BASE_BIT = 20;
  localparam int ACC_FRAC_BIT = 21;
  localparam int ACC_MAIN_PD = 19;
  localparam int ACC_AUX_PD = 18;

  localparam logic [WORD_W-1:0] CFG4_RESET = 24'h22C709;
  localparam logic [WORD_W-1:0] FRAC_EXT_RESET = 24'h00000B;
  localparam logic [WORD_W-1:0] ACCESS_RESET = 24'h1C0003;

  typedef enum logic [1:0] {
    MOD_ORDER4, MOD_OFF, MOD_ORDER2, MOD_ORDER3
  } sfcfg_mod_t;

  typedef enum logic [1:0] {
    DITHER_SELECT_NONE, DITHER_SELECT_WEAK, DITHER_SELECT_STRONG, DITHER_SELECT_RESV
  } sfcfg_dither_select_t;
endpackage

`default_nettype wire

// ==== core/sfcfg_word_if.sv ====
// carrier for a latched serial word between receiver and decoder
// assumes both ends run on the system clock
`default_nettype none

interface sfcfg_word_if;
  import sfcfg_pkg::*;
  logic [WORD_W-1:0] word;
  logic strobe;
  modport rx (output word, output strobe);
  modport core (input word, input strobe);
endinterface

`default_nettype wire

// ==== core/sfcfg_serial_rx.sv ====
// three-wire serial receiver: shifts msb first, latches on enable rise
// assumes serial pins are asynchronous and slower than the system clock
`default_nettype none

module sfcfg_serial_rx
  import sfcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_latch_in,
  sfcfg_word_if.rx word_if
);
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic clk_q_r;
  logic le_q_r;
  logic [WORD_W-1:0] shift_r;
  logic [CNT_W-1:0] count_r;
  logic [WORD_W-1:0] word_r;
  logic strobe_r;
  logic clk_rise;
  logic le_rise;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      clk_q_r <= 1'b0;
      le_q_r <= 1'b0;
    end else begin
      sync1_r <= {ser_latch_in, ser_data_in, ser_clk_in};
      sync2_r <= sync1_r;
      clk_q_r <= sync2_r[0];
      le_q_r <= sync2_r[2];
    end
  end

  assign clk_rise = sync2_r[0] & ~clk_q_r;
  assign le_rise = sync2_r[2] & ~le_q_r;

  // shifting and bit count, count restarts at each latch
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      shift_r <= '0;
      count_r <= '0;
    end else if (le_rise) begin
      count_r <= '0;
    end else if (clk_rise && !sync2_r[2]) begin
      shift_r <= {shift_r[WORD_W-2:0], sync2_r[1]};
      if (count_r != BITS_PER_WORD) begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  // only whole words are handed on
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      word_r <= '0;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= le_rise && (count_r == BITS_PER_WORD);
      if (le_rise && (count_r == BITS_PER_WORD)) begin
        word_r <= shift_r;
      end
    end
  end

  assign word_if.word = word_r;
  assign word_if.strobe = strobe_r;
endmodule

`default_nettype wire

// ==== core/sfcfg_core.sv ====
// synth config decoder: config word four, fraction extension, auto wake
// assumes fraction base bits come from same-clock logic, pins are async
`default_nettype none

module sfcfg_core
  import sfcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic ser_latch_in,
  input wire logic chip_enable_in,
  input wire logic ref_input_pin_in,
  input wire logic [sfcfg_pkg::BASE_W-1:0] frac_num_base_in,
  input wire logic [sfcfg_pkg::BASE_W-1:0] frac_den_base_in,
  output logic aux_prescaler_16_out,
  output logic main_pump_positive_out,
  output logic aux_pump_positive_out,
  output logic ref_copy_pin_out,
  output logic ref_copy_pin_oe_out,
  output logic main_ref_tick_out,
  output logic aux_ref_tick_out,
  output logic ref_doubler_enable_out,
  output sfcfg_pkg::sfcfg_mod_t modulator_order_select_out,
  output logic modulator_enable_out,
  output sfcfg_pkg::sfcfg_dither_select_t dither_select_out,
  output logic main_loop_powerdown_out,
  output logic aux_loop_powerdown_out,
  output logic frac_wide_mode_out,
  output logic [sfcfg_pkg::FRAC_W-1:0] main_frac_numerator_out,
  output logic [sfcfg_pkg::FRAC_W-1:0] main_frac_denominator_out,
  output logic access_fault_out
);
  import sfcfg_pkg::*;

  sfcfg_word_if word_bus ();

  logic [WORD_W-1:0] cfg4_r;
  logic [WORD_W-1:0] frac_ext_r;
  logic [WORD_W-1:0] access_r;
  logic main_pd_r;
  logic aux_pd_r;
  logic ce_s1_r;
  logic ce_s2_r;
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_q_r;
  logic ref_rise;
  logic ref_fall;
  logic wr_cfg4;
  logic wr_ext;
  logic wr_access;
  logic wr_freq;
  logic wide_mode;
  logic [WORD_W-1:0] ext_eff;
  logic [EXT_W-1:0] num_hi;
  logic [EXT_W-1:0] den_hi;

  function automatic sfcfg_mod_t decode_order(input logic [1:0] code);
    sfcfg_mod_t m;
    case (code)
      2'h0: m = MOD_ORDER4;
      2'h1: m = MOD_OFF;
      2'h2: m = MOD_ORDER2;
      default: m = MOD_ORDER3;
    endcase
    return m;
  endfunction

  function automatic sfcfg_dither_select_t decode_dither(input logic [1:0] code);
    sfcfg_dither_select_t d;
    case (code)
      2'h0: d = DITHER_SELECT_NONE;
      2'h1: d = DITHER_SELECT_WEAK;
      2'h2: d = DITHER_SELECT_STRONG;
      default: d = DITHER_SELECT_RESV;
    endcase
    return d;
  endfunction

  // builds a fraction value from base and extension bits
  function automatic logic [FRAC_W-1:0] frac_value(
    input logic wide,
    input logic [EXT_W-1:0] hi,
    input logic [BASE_W-1:0] lo
  );
    logic [FRAC_W-1:0] v;
    if (wide) begin
      v = {hi, lo};
    end else begin
      v = {{EXT_W{1'b0}}, lo};
    end
    return v;
  endfunction

  // true when a latched word carries the given select nibble
  function automatic logic sel_match(
    input logic [WORD_W-1:0] w,
    input logic [SEL_W-1:0] sel
  );
    return w[SEL_W-1:0] == sel;
  endfunction

  sfcfg_serial_rx u_rx (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in),
    .ser_latch_in(ser_latch_in),
    .word_if(word_bus.rx)
  );

  // word select decode
  always_comb begin
    wr_cfg4 = 1'b0;
    wr_ext = 1'b0;
    wr_access = 1'b0;
    wr_freq = 1'b0;
    if (!word_bus.strobe) begin
      wr_cfg4 = 1'b0;
    end else if (sel_match(word_bus.word, SEL_CFG4)) begin
      wr_cfg4 = 1'b1;
    end else if (sel_match(word_bus.word, SEL_FRAC_EXT)) begin
      wr_ext = 1'b1;
    end else if (sel_match(word_bus.word, SEL_ACCESS)) begin
      wr_access = 1'b1;
    end else if ((word_bus.word[SEL_W-1:0] & SEL_FREQ_MASK) ==
                 SEL_FREQ_VAL) begin
      wr_freq = 1'b1;
    end
  end

  // stored words
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg4_r <= CFG4_RESET;
    end else if (wr_cfg4) begin
      cfg4_r <= word_bus.word;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      frac_ext_r <= FRAC_EXT_RESET;
    end else if (wr_ext) begin
      frac_ext_r <= word_bus.word;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      access_r <= ACCESS_RESET;
    end else if (wr_access) begin
      access_r <= word_bus.word;
    end
  end

  // chip enable sync
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
    end else begin
      ce_s1_r <= chip_enable_in;
      ce_s2_r <= ce_s1_r;
    end
  end

  // power-down bits: access word sets them, auto wake clears them
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      main_pd_r <= ACCESS_RESET[ACC_MAIN_PD];
      aux_pd_r <= ACCESS_RESET[ACC_AUX_PD];
    end else if (wr_access) begin
      main_pd_r <= word_bus.word[ACC_MAIN_PD];
      aux_pd_r <= word_bus.word[ACC_AUX_PD];
    end else if (wr_freq && cfg4_r[CFG4_AUTO_WAKE] && ce_s2_r) begin
      main_pd_r <= 1'b0;
      aux_pd_r <= 1'b0;
    end
  end

  // reference input sync and edge detect
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_q_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_input_pin_in;
      ref_s2_r <= ref_s1_r;
      ref_q_r <= ref_s2_r;
    end
  end

  assign ref_rise = ref_s2_r & ~ref_q_r;
  assign ref_fall = ~ref_s2_r & ref_q_r;

  // reference counter ticks; both edges double the main rate
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      main_ref_tick_out <= 1'b0;
      aux_ref_tick_out <= 1'b0;
    end else begin
      main_ref_tick_out <= ref_rise |
        (cfg4_r[CFG4_DOUBLER] & ref_fall);
      aux_ref_tick_out <= ref_rise;
    end
  end

  // reference copy pin
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ref_copy_pin_out <= 1'b0;
      ref_copy_pin_oe_out <= 1'b0;
    end else begin
      ref_copy_pin_out <= ref_s2_r & cfg4_r[CFG4_REF_OUT];
      ref_copy_pin_oe_out <= cfg4_r[CFG4_REF_OUT];
    end
  end

  // loop control levels
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      aux_prescaler_16_out <= CFG4_RESET[CFG4_AUX_PRESC];
      main_pump_positive_out <= CFG4_RESET[CFG4_MAIN_CPP];
      aux_pump_positive_out <= CFG4_RESET[CFG4_AUX_CPP];
      ref_doubler_enable_out <= CFG4_RESET[CFG4_DOUBLER];
    end else begin
      aux_prescaler_16_out <= cfg4_r[CFG4_AUX_PRESC];
      main_pump_positive_out <= cfg4_r[CFG4_MAIN_CPP];
      aux_pump_positive_out <= cfg4_r[CFG4_AUX_CPP];
      ref_doubler_enable_out <= cfg4_r[CFG4_DOUBLER];
    end
  end

  // modulator order and its enable
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      modulator_order_select_out <=
        decode_order(CFG4_RESET[CFG4_ORDER_LSB +: 2]);
      modulator_enable_out <=
        (decode_order(CFG4_RESET[CFG4_ORDER_LSB +: 2]) != MOD_OFF);
    end else begin
      modulator_order_select_out <=
        decode_order(cfg4_r[CFG4_ORDER_LSB +: 2]);
      modulator_enable_out <=
        (decode_order(cfg4_r[CFG4_ORDER_LSB +: 2]) != MOD_OFF);
    end
  end

  // dither strength
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dither_select_out <= decode_dither(CFG4_RESET[CFG4_DITHER_SELECT_LSB +: 2]);
    end else begin
      dither_select_out <= decode_dither(cfg4_r[CFG4_DITHER_SELECT_LSB +: 2]);
    end
  end

  // default contents stand in while the word is not programmable
  assign wide_mode = access_r[ACC_FRAC_BIT];
  assign ext_eff = wide_mode ? frac_ext_r : FRAC_EXT_RESET;
  assign num_hi = ext_eff[EXT_NUM_LSB +: EXT_W];
  assign den_hi = ext_eff[EXT_DEN_LSB +: EXT_W];

  // fraction width follows the access word
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      frac_wide_mode_out <= ACCESS_RESET[ACC_FRAC_BIT];
    end else begin
      frac_wide_mode_out <= wide_mode;
    end
  end

  // fraction values, low bits straight from the base inputs
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      main_frac_numerator_out <= '0;
      main_frac_denominator_out <= '0;
    end else begin
      main_frac_numerator_out <=
        frac_value(wide_mode, num_hi, frac_num_base_in);
      main_frac_denominator_out <=
        frac_value(wide_mode, den_hi, frac_den_base_in);
    end
  end

  // access word bit 20 must be held at one
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      access_fault_out <= ~ACCESS_RESET[ACC_BASE_BIT];
    end else begin
      access_fault_out <= ~access_r[ACC_BASE_BIT];
    end
  end

  // power-down levels handed to both loops
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      main_loop_powerdown_out <= ACCESS_RESET[ACC_MAIN_PD];
      aux_loop_powerdown_out <= ACCESS_RESET[ACC_AUX_PD];
    end else begin
      main_loop_powerdown_out <= main_pd_r;
      aux_loop_powerdown_out <= aux_pd_r;
    end
  end
endmodule

`default_nettype wire

// ==== dv/sfcfg_props.sv ====
// checker for the synth config decoder, watching top ports only
// assumes it is bound onto sfcfg_core
`default_nettype none

module sfcfg_props
  import sfcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ser_latch_in,
  input wire logic [sfcfg_pkg::BASE_W-1:0] frac_num_base_in,
  input wire logic [sfcfg_pkg::BASE_W-1:0] frac_den_base_in,
  input wire logic aux_prescaler_16_out,
  input wire logic ref_copy_pin_out,
  input wire logic ref_copy_pin_oe_out,
  input wire logic main_ref_tick_out,
  input wire logic aux_ref_tick_out,
  input wire logic ref_doubler_enable_out,
  input wire sfcfg_pkg::sfcfg_mod_t modulator_order_select_out,
  input wire logic modulator_enable_out,
  input wire sfcfg_pkg::sfcfg_dither_select_t dither_select_out,
  input wire logic frac_wide_mode_out,
  input wire logic [sfcfg_pkg::FRAC_W-1:0] main_frac_numerator_out,
  input wire logic [sfcfg_pkg::FRAC_W-1:0] main_frac_denominator_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [3:0] quiet_r;

  // cycles since the latch pin last moved, saturating
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || $changed(ser_latch_in))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hF)
      quiet_r <= quiet_r + 4'h1;
  end

  mod_enable_a: assert property ($stable(modulator_order_select_out) |->
    modulator_enable_out == (modulator_order_select_out != MOD_OFF))
    else $error("modulator enable disagrees with order");
  copy_hiz_a: assert property (!ref_copy_pin_oe_out |-> !ref_copy_pin_out)
    else $error("copy pin active while disabled");
  aux_pulse_a: assert property (aux_ref_tick_out |=> !aux_ref_tick_out)
    else $error("aux tick longer than one cycle");
  tick_pair_a: assert property (aux_ref_tick_out |-> main_ref_tick_out)
    else $error("main tick missing on reference rise");
  no_double_a: assert property (
    !ref_doubler_enable_out && main_ref_tick_out |-> aux_ref_tick_out)
    else $error("extra main tick with doubler off");
  narrow_num_a: assert property (
    (!frac_wide_mode_out) [*2] |-> main_frac_numerator_out[21:12] == 10'h0)
    else $error("numerator upper bits used in narrow mode");
  narrow_den_a: assert property (
    (!frac_wide_mode_out) [*2] |-> main_frac_denominator_out[21:12] == 10'h0)
    else $error("denominator upper bits used in narrow mode");
  base_num_a: assert property ($past(rst_n_in) |->
    main_frac_numerator_out[11:0] == $past(frac_num_base_in))
    else $error("numerator low bits not from base");
  base_den_a: assert property ($past(rst_n_in) |->
    main_frac_denominator_out[11:0] == $past(frac_den_base_in))
    else $error("denominator low bits not from base");
  word_quiet_a: assert property (quiet_r >= 4'hC |->
    $stable(modulator_order_select_out) && $stable(dither_select_out)
    && $stable(aux_prescaler_16_out))
    else $error("config changed without a latched word");
endmodule

bind sfcfg_core sfcfg_props u_props (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .ser_latch_in(ser_latch_in),
  .frac_num_base_in(frac_num_base_in),
  .frac_den_base_in(frac_den_base_in),
  .aux_prescaler_16_out(aux_prescaler_16_out),
  .ref_copy_pin_out(ref_copy_pin_out),
  .ref_copy_pin_oe_out(ref_copy_pin_oe_out),
  .main_ref_tick_out(main_ref_tick_out),
  .aux_ref_tick_out(aux_ref_tick_out),
  .ref_doubler_enable_out(ref_doubler_enable_out),
  .modulator_order_select_out(modulator_order_select_out),
  .modulator_enable_out(modulator_enable_out),
  .dither_select_out(dither_select_out),
  .frac_wide_mode_out(frac_wide_mode_out),
  .main_frac_numerator_out(main_frac_numerator_out),
  .main_frac_denominator_out(main_frac_denominator_out)
);

`default_nettype wire

// ==== dv/sfcfg_host.sv ====
// host model writing control words over the three-wire serial port
// assumes the system clock paces it; link clock idles low between words
`default_nettype none

module sfcfg_host (
  input wire logic clk_sys_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_latch_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_latch_out = 1'b0;
  end

  // top n bits msb first at 80 ns per bit, then a latch pulse
  task automatic send(input logic [23:0] w, input int n);
    for (int i = 23; i > 23 - n; i--) begin
      repeat (8) @(posedge clk_sys_in);
      ser_data_out <= w[i];
      ser_clk_out <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      ser_clk_out <= 1'b1;
    end
    repeat (8) @(posedge clk_sys_in);
    ser_clk_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    ser_latch_out <= 1'b1;
    ser_data_out <= ~ser_data_out;
    repeat (8) @(posedge clk_sys_in);
    ser_latch_out <= 1'b0;
    repeat (12) @(posedge clk_sys_in);
  endtask
endmodule

`default_nettype wire

// ==== dv/sfcfg_core_test.sv ====
// self-checking bench for the synth config decoder
// assumes sfcfg_host drives the serial pins and the checker is bound
`default_nettype none

module sfcfg_core_test;
  import sfcfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce = 1'b1;
  logic ref_in = 1'b0;
  logic [11:0] num_b = 12'h000;
  logic [11:0] den_b = 12'h3E8;
  logic ser_clk, ser_data, ser_latch;
  logic presc, mpp, app, copy, oe, mtick, atick, dbl, men, pdm, pda;
  logic wide, fault;
  sfcfg_mod_t ord;
  sfcfg_dither_select_t dither_select;
  logic [21:0] num, den;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_main = 0;
  int n_aux = 0;
  logic [4:0] b;
  wire logic [21:0] obs = {12'h0, presc, mpp, app, dbl, oe, ord, men, dither_select};
  wire logic [21:0] pd = {20'h0, pdm, pda};

  always #2.5 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    n_main += int'(mtick);
    n_aux += int'(atick);
  end

  sfcfg_host u_host (.clk_sys_in(clk_sys_in), .ser_clk_out(ser_clk),
    .ser_data_out(ser_data), .ser_latch_out(ser_latch));

  sfcfg_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ser_clk_in(ser_clk), .ser_data_in(ser_data), .ser_latch_in(ser_latch),
    .chip_enable_in(ce), .ref_input_pin_in(ref_in),
    .frac_num_base_in(num_b), .frac_den_base_in(den_b),
    .aux_prescaler_16_out(presc), .main_pump_positive_out(mpp),
    .aux_pump_positive_out(app), .ref_copy_pin_out(copy),
    .ref_copy_pin_oe_out(oe), .main_ref_tick_out(mtick),
    .aux_ref_tick_out(atick), .ref_doubler_enable_out(dbl),
    .modulator_order_select_out(ord), .modulator_enable_out(men),
    .dither_select_out(dither_select), .main_loop_powerdown_out(pdm),
    .aux_loop_powerdown_out(pda), .frac_wide_mode_out(wide),
    .main_frac_numerator_out(num), .main_frac_denominator_out(den),
    .access_fault_out(fault));

  function automatic logic [23:0] cfg(logic aw, logic [1:0] o, logic [4:0] c);
    cfg = {aw, 5'h08, o, o, 1'b0, c, 4'h0, SEL_CFG4};
  endfunction

  function automatic logic [23:0] acc(logic a1, logic a0, logic [1:0] p);
    acc = {2'h0, a1, a0, p, 14'h0, SEL_ACCESS};
  endfunction

  function automatic logic [21:0] ob(logic [4:0] c, logic [1:0] o);
    ob = {12'h0, c[0], c[1], c[2], c[4], c[3], o, o != 2'h1, o};
  endfunction

  task automatic chk(string nm, logic [21:0] e, logic [21:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pulses(logic ev);
    n_main = 0;
    n_aux = 0;
    repeat (4) begin
      repeat (10) @(posedge clk_sys_in);
      ref_in <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      chk("copy pin", {21'h0, ev}, {21'h0, copy});
      ref_in <= 1'b0;
    end
    repeat (10) @(posedge clk_sys_in);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("cfg reset", 22'h39E, obs);
    chk("pd reset", 22'h3, pd);
    chk("fault reset", 22'h0, {21'h0, fault});
    for (int i = 0; i < 4; i++) begin
      b = i[0] ? 5'h0A : 5'h15;
      u_host.send(cfg(1'b0, i[1:0], b), 24);
      chk("cfg decode", ob(b, i[1:0]), obs);
    end
    pulses(1'b1);
    chk("main ticks", 22'h4, 22'(n_main));
    chk("aux ticks", 22'h4, 22'(n_aux));
    u_host.send(cfg(1'b0, 2'h0, 5'h15), 24);
    pulses(1'b0);
    chk("main ticks x2", 22'h8, 22'(n_main));
    chk("aux ticks x2", 22'h4, 22'(n_aux));
    u_host.send(cfg(1'b0, 2'h1, 5'h0A), 23);
    chk("short word", ob(5'h15, 2'h0), obs);
    u_host.send(24'hFFFFF5, 24);
    chk("bad select", ob(5'h15, 2'h0), obs);
    chk("bad select pd", 22'h3, pd);
    den_b <= 12'hFFF;
    u_host.send(acc(1'b0, 1'b1, 2'h3), 24);
    u_host.send({10'h3FF, 10'h001, SEL_FRAC_EXT}, 24);
    chk("num narrow", 22'h0, num);
    chk("den narrow", 22'hFFF, den);
    u_host.send(acc(1'b1, 1'b1, 2'h3), 24);
    chk("num wide", 22'h1000, num);
    chk("den wide", 22'h3FFFFF, den);
    chk("wide", 22'h1, {21'h0, wide});
    u_host.send(acc(1'b1, 1'b0, 2'h3), 24);
    chk("fault", 22'h1, {21'h0, fault});
    u_host.send(acc(1'b1, 1'b1, 2'h3), 24);
    chk("fault clear", 22'h0, {21'h0, fault});
    u_host.send(24'h000010, 24);
    chk("pd no wake", 22'h3, pd);
    u_host.send(cfg(1'b1, 2'h0, 5'h15), 24);
    ce <= 1'b0;
    u_host.send(24'h000010, 24);
    chk("pd ce low", 22'h3, pd);
    ce <= 1'b1;
    u_host.send(24'h000010, 24);
    chk("pd wake", 22'h0, pd);
    end_of_test();
  end
endmodule

`default_nettype wire
